// File: core/adc_ctrl_defs.svh
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// Register byte offsets
`define OFF_MODE 12'h000
`define OFF_CHAN 12'h004
`define OFF_PORT 12'h008
`define OFF_RES10 12'h00C
`define OFF_RES8 12'h010
`define OFF_IFLAG 12'h014

// Mode register fields, register reset values and masks
`define MODE_START_BIT 7
`define MODE_RATE_HI 5
`define MODE_RATE_LO 1
`define MODE_ENABLE_BIT 0
`define MODE_RESET 8'h00
`define CHAN_RESET 8'h00
`define PORT_RESET 8'h00
`define CHAN_MASK 8'h07
`define PORT_MASK 8'h0F

// Conversion timing
`define CLK_MHZ 40
`define EXTRA_SETUP_CYC 8
`define BASE_CONV_CYC 8
`define STEP_CONV_CYC 4

`endif

// File: core/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_CONV = 4'b0100,
        ST_DONE = 4'b1000
    } conv_state_t;

    typedef struct packed {
        logic [9:0] data;
        logic valid;
    } result_t;
endpackage

// File: core/adc_ctrl.sv
`timescale 1ns/10ps
`include "adc_ctrl_defs.svh"

// Behaviour
// - Channel select write adds one wait
// - Port config write adds one wait
// - Only final phase equals selected conversion time
// - Halt in stop; clear enable bit cuts current
// - Result read wins, new result later
// - Control write wins, result and irq dropped
// - Channel change keeps end flag
module adc_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int RES_W = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter side
    input wire logic stop_mode,
    input wire logic [RES_W-1:0] sar_result,
    output logic comparator_on,
    output logic [2:0] analog_inputs_sel,
    output logic conversion_end_irq
);

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic [7:0] converter_mode_reg_q;
    logic [7:0] channel_select_reg_q;
    logic [7:0] analog_port_config_reg_q;
    logic [RES_W-1:0] result_reg_10bit_q;
    logic conversion_end_flag_q;
    logic wait_q;
    result_t pend_q;
    conv_state_t state_q;
    logic [7:0] cnt_q;
    logic done_pulse;
    logic access;
    logic wr_mode;
    logic wr_chan;
    logic wr_port;
    logic wr_flag;
    logic rd_res;
    logic needs_wait;
    logic ctl_write;
    logic [7:0] conv_cycles;

    assign access = psel && penable;
    assign wr_mode = access && pwrite && paddr == `OFF_MODE;
    assign wr_chan = access && pwrite && paddr == `OFF_CHAN && pready;
    assign wr_port = access && pwrite && paddr == `OFF_PORT && pready;
    assign wr_flag = access && pwrite && paddr == `OFF_IFLAG;
    assign rd_res = access && !pwrite && (paddr == `OFF_RES10 || paddr == `OFF_RES8);
    assign needs_wait = pwrite && (paddr == `OFF_CHAN || paddr == `OFF_PORT);
    // Any control write that collides with completion
    assign ctl_write = psel && pwrite
        && (paddr == `OFF_MODE || paddr == `OFF_CHAN || paddr == `OFF_PORT);

    // ************************************************************
    // Wait insertion
    // ************************************************************
    // One extra access cycle before channel or port writes complete
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 1'b0;
        end else if (access && needs_wait && !wait_q) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= 1'b0;
        end
    end

    assign pready = !(access && needs_wait && !wait_q);
    assign pslverr = 1'b0;

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_mode_reg_q <= `MODE_RESET;
        end else if (wr_mode) begin
            converter_mode_reg_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_select_reg_q <= `CHAN_RESET;
        end else if (wr_chan) begin
            channel_select_reg_q <= pwdata[7:0] & `CHAN_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_port_config_reg_q <= `PORT_RESET;
        end else if (wr_port) begin
            analog_port_config_reg_q <= pwdata[7:0] & `PORT_MASK;
        end
    end

    assign analog_inputs_sel = channel_select_reg_q[2:0];
    // Operating current is removed only with the enable bit clear
    assign comparator_on = converter_mode_reg_q[`MODE_ENABLE_BIT];

    // ************************************************************
    // Conversion sequencer
    // ************************************************************
    assign conv_cycles = 8'(`BASE_CONV_CYC)
        + 8'(converter_mode_reg_q[`MODE_RATE_HI:`MODE_RATE_LO]) * 8'(`STEP_CONV_CYC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
        end else if (stop_mode || !converter_mode_reg_q[`MODE_START_BIT]) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= ST_SETUP;
                    cnt_q <= 8'(`EXTRA_SETUP_CYC);
                end
                ST_SETUP: begin
                    // Setup phase lengthens the first interval only
                    if (cnt_q == 8'h01) begin
                        state_q <= ST_CONV;
                        cnt_q <= conv_cycles;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ST_CONV: begin
                    if (cnt_q == 8'h01) begin
                        state_q <= ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_CONV;
                    cnt_q <= conv_cycles;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign done_pulse = state_q == ST_DONE;

    // ************************************************************
    // Result storage and end flag
    // ************************************************************
    // A result held back by a read is written the cycle after
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= '0;
            result_reg_10bit_q <= '0;
        end else if (done_pulse && ctl_write) begin
            pend_q <= '0;
        end else if (done_pulse && rd_res) begin
            pend_q <= '{data: sar_result, valid: 1'b1};
        end else if (done_pulse) begin
            result_reg_10bit_q <= sar_result;
            pend_q <= '0;
        end else if (pend_q.valid && !rd_res) begin
            result_reg_10bit_q <= pend_q.data;
            pend_q <= '0;
        end
    end

    logic store_evt;
    assign store_evt = (done_pulse && !ctl_write && !rd_res)
        || (pend_q.valid && !rd_res && !done_pulse);

    // Set wins over the software clear; channel writes leave it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_end_flag_q <= 1'b0;
        end else if (store_evt) begin
            conversion_end_flag_q <= 1'b1;
        end else if (wr_flag && !pwdata[0]) begin
            conversion_end_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_end_irq <= 1'b0;
        end else begin
            conversion_end_irq <= store_evt;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == `OFF_MODE) begin
            prdata[7:0] = converter_mode_reg_q;
        end else if (paddr == `OFF_CHAN) begin
            prdata[7:0] = channel_select_reg_q;
        end else if (paddr == `OFF_PORT) begin
            prdata[7:0] = analog_port_config_reg_q;
        end else if (paddr == `OFF_RES10) begin
            prdata[RES_W-1:0] = result_reg_10bit_q;
        end else if (paddr == `OFF_RES8) begin
            prdata[7:0] = result_reg_10bit_q[RES_W-1:RES_W-8];
        end else if (paddr == `OFF_IFLAG) begin
            prdata[0] = conversion_end_flag_q;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_wait_chan: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && pwrite && paddr == `OFF_CHAN ##1 psel && penable
        |-> !pready ##1 pready) else $error("channel write lacks one wait");
    chk_wait_port: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && pwrite && paddr == `OFF_PORT ##1 psel && penable
        |-> !pready ##1 pready) else $error("port write lacks one wait");
    chk_stop_idle: assert property (@(posedge pclk) disable iff (!presetn)
        stop_mode |=> state_q == ST_IDLE) else $error("converter runs in stop");
    chk_conv_time: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_q == ST_CONV) && !stop_mode |-> cnt_q == conv_cycles)
        else $error("conversion time wrong");
    chk_read_old: assert property (@(posedge pclk) disable iff (!presetn)
        done_pulse && rd_res && !ctl_write |=> pend_q.valid
        && $stable(result_reg_10bit_q)) else $error("read lost old result");
    chk_ctl_drop: assert property (@(posedge pclk) disable iff (!presetn)
        done_pulse && ctl_write && !pend_q.valid |=> !conversion_end_irq
        && $stable(result_reg_10bit_q)) else $error("result not dropped");
    chk_chan_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        conversion_end_flag_q && wr_chan |=> conversion_end_flag_q)
        else $error("channel write cleared flag");
    chk_irq_store: assert property (@(posedge pclk) disable iff (!presetn)
        conversion_end_irq |-> $past(store_evt) && conversion_end_flag_q)
        else $error("irq without stored result");

    // ************************************************************
    // Sequencer, storage and bus checks
    // ************************************************************
    // These guard paths that bench traffic reaches only now and then
    chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        store_evt |=> conversion_end_flag_q)
        else $error("stored result left flag clear");
    chk_pend_drain: assert property (@(posedge pclk) disable iff (!presetn)
        pend_q.valid && !rd_res && !done_pulse |=> !pend_q.valid
        && result_reg_10bit_q == $past(pend_q.data)) else $error("held result lost");
    chk_idle_ready: assert property (@(posedge pclk) disable iff (!presetn)
        !access |-> pready)
        else $error("ready low outside access");
    chk_read_fast: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite |-> pready)
        else $error("read got a wait");
    chk_stop_done: assert property (@(posedge pclk) disable iff (!presetn)
        stop_mode |=> !done_pulse)
        else $error("conversion ended in stop");
    chk_irq_single: assert property (@(posedge pclk) disable iff (!presetn)
        conversion_end_irq |=> !conversion_end_irq)
        else $error("irq longer than one cycle");
    chk_ctl_flag: assert property (@(posedge pclk) disable iff (!presetn)
        done_pulse && ctl_write && !pend_q.valid && !conversion_end_flag_q
        |=> !conversion_end_flag_q) else $error("dropped result set flag");
    chk_setup_len: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_q == ST_SETUP) |-> cnt_q == 8'(`EXTRA_SETUP_CYC))
        else $error("setup phase length wrong");
    chk_start_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !converter_mode_reg_q[`MODE_START_BIT] |=> state_q == ST_IDLE)
        else $error("runs with start clear");
    chk_setup_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_SETUP && !pend_q.valid |=> !conversion_end_irq)
        else $error("irq during setup");

endmodule

// File: tb/tb_adc_ctrl.sv
`timescale 1ns/10ps
`include "adc_ctrl_defs.svh"

module tb_adc_ctrl;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic stop_mode = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [9:0] sar_result = 10'h2A5;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic comparator_on;
    logic [2:0] analog_inputs_sel;
    logic conversion_end_irq;
    int n_errors = 0;
    int tests_run = 0;
    int waits;
    int irq_cnt = 0;
    int cyc = 0;
    int t_last = 0;
    int t_prev = 0;
    int p0;
    int p3;
    int base;
    bit seen_new;

    always #12.5 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc++;
        if (conversion_end_irq === 1'b1) begin
            irq_cnt++;
            t_prev = t_last;
            t_last = cyc;
        end
    end

    adc_ctrl #(.RES_W(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
        .sar_result(sar_result), .comparator_on(comparator_on),
        .analog_inputs_sel(analog_inputs_sel), .conversion_end_irq(conversion_end_irq));

    // ****************************************
    // Bus and checking tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Leaves psel up so a following call makes a back-to-back transfer
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            @(posedge pclk);
        end
        waits = n;
        rd = prdata;
    endtask

    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        idle();
    endtask

    task automatic rreg(input logic [11:0] a);
        xfer(1'b0, a, 32'h0);
        idle();
    endtask

    task automatic wait_irq(input int n);
        int k;
        k = 0;
        while (irq_cnt < n && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        check("irq arrival", irq_cnt >= n, 1'b1);
    endtask

    // Period between two results at a given rate field
    task automatic period(input int r, output int p);
        wreg(`OFF_MODE, 32'h01 | (r << 1));
        repeat (40) @(posedge pclk);
        wreg(`OFF_MODE, 32'h81 | (r << 1));
        wait_irq(irq_cnt + 3);
        p = t_last - t_prev;
        wreg(`OFF_MODE, 32'h00);
    endtask

    task automatic end_of_test();
        $display("counts: %0d compared, %0d mismatched", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        logic [11:0] offs [5];
        int exp_w [5];
        offs = '{`OFF_MODE, `OFF_CHAN, `OFF_PORT, `OFF_IFLAG, 12'h020};
        exp_w = '{0, 1, 1, 0, 0};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            rreg(offs[i]);
            check("reset value", rd, 32'h0);
            check("read waits", waits, 0);
            check("no error", pslverr, 1'b0);
        end
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, offs[i], (i == 0) ? 32'h00 : 32'h06);
            check("write waits", waits, exp_w[i]);
            idle();
        end
        rreg(12'h020);
        check("unmapped read", rd, 32'h0);
        check("channel pins", analog_inputs_sel, 3'h6);
        $display("test wait cycles done");
        period(0, p0);
        period(3, p3);
        check("rate step", p3 - p0, 12);
        check("period floor", p0 >= `BASE_CONV_CYC, 1);
        rreg(`OFF_RES10);
        check("result 10 bit", rd, 32'h2A5);
        rreg(`OFF_RES8);
        check("result upper", rd, 32'hA9);
        $display("test conversion time done");
        wreg(`OFF_CHAN, 32'h03);
        rreg(`OFF_IFLAG);
        check("flag kept", rd, 32'h1);
        wreg(`OFF_IFLAG, 32'h0);
        rreg(`OFF_IFLAG);
        check("flag cleared", rd, 32'h0);
        $display("test channel flag done");
        stop_mode <= 1'b1;
        base = irq_cnt;
        wreg(`OFF_MODE, 32'h81);
        check("comparator on", comparator_on, 1'b1);
        repeat (200) @(posedge pclk);
        check("stop halts", irq_cnt - base, 0);
        wreg(`OFF_IFLAG, 32'h0);
        stop_mode <= 1'b0;
        wait_irq(base + 1);
        check("resume", irq_cnt - base, 1);
        $display("test stop mode done");
        // Result changes only after the last stored one has signalled
        sar_result <= 10'h15A;
        base = irq_cnt;
        for (int i = 0; i < 30; i++)
            xfer(1'b1, `OFF_PORT, 32'h01);
        xfer(1'b1, `OFF_MODE, 32'h00);
        idle();
        check("irq dropped", irq_cnt - base, 0);
        rreg(`OFF_RES10);
        check("result dropped", rd, 32'h2A5);
        check("comparator off", comparator_on, 1'b0);
        $display("test control collision done");
        wreg(`OFF_MODE, 32'h81);
        base = irq_cnt;
        seen_new = 1'b0;
        for (int i = 0; i < 40; i++) begin
            xfer(1'b0, `OFF_RES10, 32'h0);
            if (seen_new)
                check("read after store", rd, 32'h15A);
            else if (rd !== 32'h2A5)
                check("read old or new", rd, 32'h15A);
            seen_new = seen_new | (rd === 32'h15A);
        end
        idle();
        check("stored despite reads", irq_cnt - base >= 2, 1);
        check("new seen", seen_new, 1'b1);
        $display("test read collision done");
        end_of_test();
    end

    initial begin
        #1500000;
        n_errors++;
        end_of_test();
    end
endmodule
